//--- common/fpdb_pkg.sv
// Constants for the front panel display blanking block.
// Assumes a 125 MHz core clock and an AXI4-Lite register master.
package fpdb_pkg;
    // Register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAGE_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    // Field positions in control and staging words
    localparam int STYLE_LSB = 0;
    localparam int DELAY_LSB = 4;
    localparam int MANUAL_LSB = 8;
    // Reset values
    localparam logic [1:0] STYLE_RST = 2'h0;
    localparam logic [2:0] DELAY_RST = 3'h0;
    localparam logic [3:0] MANUAL_RST = 4'h0;
    // Alarm display styles
    localparam logic [1:0] STYLE_PLAIN = 2'h0;
    localparam logic [1:0] STYLE_ALTERNATE = 2'h1;
    localparam logic [1:0] STYLE_FLASH = 2'h2;
    localparam logic [1:0] STYLE_TAG_ONLY = 2'h3;
    // Auto-blank delay codes
    localparam logic [2:0] DELAY_OFF = 3'h0;
    localparam logic [2:0] DELAY_15S = 3'h1;
    localparam logic [2:0] DELAY_30S = 3'h2;
    localparam logic [2:0] DELAY_1M = 3'h3;
    localparam logic [2:0] DELAY_5M = 3'h4;
    // Auto-blank delays in seconds
    localparam logic [8:0] AUTO_15S_S = 9'd15;
    localparam logic [8:0] AUTO_30S_S = 9'd30;
    localparam logic [8:0] AUTO_1M_S = 9'd60;
    localparam logic [8:0] AUTO_5M_S = 9'd300;
    // Manual blanking
    localparam logic [3:0] MANUAL_RELIGHT_MIN = 4'h5;
    localparam logic [3:0] MANUAL_MAX = 4'h8;
    localparam logic [2:0] RELIGHT_S = 3'd5;
    // Blank mask bits: set value, process value, lamps
    localparam int MASK_SV = 0;
    localparam int MASK_PV = 1;
    localparam int MASK_LAMP = 2;
    // Seconds tick
    localparam longint SECOND_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 8;
    localparam int TICK_CYCLES_DEF = int'(SECOND_NS / CLK_PERIOD_NS);
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Edit states
    typedef enum logic [1:0] {
        EDIT_IDLE = 2'b01,
        EDIT_ACTIVE = 2'b10
    } fpdb_edit_t;
endpackage

//--- core/fpdb_top.sv
// Front panel display policy: alarm display style, auto blanking,
// manual blanking with key relight, and parameter edit commit.
// Assumes key and alarm inputs synchronous to core_clk, keys as pulses.
`timescale 1ns/10ps
module fpdb_top
    import fpdb_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Front panel keys
    input wire logic key_press,
    input wire logic key_select,
    input wire logic on_config_param,
    // Process conditions
    input wire logic first_alarm,
    input wire logic second_alarm,
    input wire logic input_error,
    // Display and lamp drivers
    output logic pv_on,
    output logic sv_on,
    output logic pv_show_tag,
    output logic pv_tag_second,
    output logic pv_flash,
    output logic pv_lamp_on,
    output logic pv_lamp_blink,
    output logic sv_lamp_on,
    output logic other_lamps_on,
    output logic digit_blink,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    function automatic logic [8:0] delay_limit(input logic [2:0] code);
        case (code)
            DELAY_15S: delay_limit = AUTO_15S_S;
            DELAY_30S: delay_limit = AUTO_30S_S;
            DELAY_1M: delay_limit = AUTO_1M_S;
            DELAY_5M: delay_limit = AUTO_5M_S;
            default: delay_limit = 9'd0;
        endcase
    endfunction
    function automatic logic [2:0] blank_mask(input logic [3:0] choice);
        logic [3:0] base;
        base = (choice >= MANUAL_RELIGHT_MIN && choice <= MANUAL_MAX) ? choice - 4'h4 : choice;
        case (base)
            4'h1: blank_mask = 3'b001;
            4'h2: blank_mask = 3'b010;
            4'h3: blank_mask = 3'b011;
            4'h4: blank_mask = 3'b111;
            default: blank_mask = 3'b000;
        endcase
    endfunction
    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
    // Configuration state
    logic [1:0] style_q;
    logic [2:0] delay_q;
    logic [3:0] manual_q;
    logic [31:0] stage_q;
    fpdb_edit_t edit_q;
    // Timing state
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic phase_q;
    logic [8:0] idle_q;
    logic [2:0] relight_q;
    // Bus state
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    // Condition decode
    wire logic any_alarm = first_alarm | second_alarm;
    wire logic trouble = any_alarm | input_error;
    wire logic [8:0] limit = delay_limit(delay_q);
    wire logic relight_kind = manual_q >= MANUAL_RELIGHT_MIN && manual_q <= MANUAL_MAX;
    wire logic relight_on = relight_kind && relight_q != 3'd0;
    wire logic auto_blank = limit != 9'd0 && idle_q >= limit && !trouble;
    wire logic manual_act = !trouble && !relight_on;
    wire logic [2:0] mask = manual_act ? blank_mask(manual_q) : 3'b000;
    // Bus decode
    wire logic aw_hs = s_axi_awvalid & s_axi_awready;
    wire logic w_hs = s_axi_wvalid & s_axi_wready;
    wire logic do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire logic wr_ctrl = do_write && awaddr_q[3:2] == CTRL_OFS[3:2];
    wire logic wr_stage = do_write && awaddr_q[3:2] == STAGE_OFS[3:2];
    wire logic wr_status = do_write && awaddr_q[3:2] == STATUS_OFS[3:2];
    wire logic [31:0] wmask = strobe_mask(wstrb_q);
    wire logic [31:0] ctrl_word = {20'h0_0000, manual_q, 1'b0, delay_q, 2'h0, style_q};
    wire logic [31:0] ctrl_new = (ctrl_word & ~wmask) | (wdata_q & wmask);
    wire logic [31:0] stage_new = (stage_q & ~wmask) | (wdata_q & wmask);
    wire logic [31:0] status_word = {22'h00_0000, edit_q == EDIT_ACTIVE, phase_q,
                                     relight_on, auto_blank, mask, trouble, tick_q, 1'b0};
    wire logic ar_hs = s_axi_arvalid & s_axi_arready;
    wire logic rd_ctrl = s_axi_araddr[3:2] == CTRL_OFS[3:2];
    wire logic rd_stage = s_axi_araddr[3:2] == STAGE_OFS[3:2];
    wire logic rd_status = s_axi_araddr[3:2] == STATUS_OFS[3:2];
    wire logic [31:0] rd_word = rd_ctrl ? ctrl_word : rd_stage ? stage_q :
                                rd_status ? status_word : 32'h0000_0000;
    wire logic edit_start = edit_q == EDIT_IDLE && key_select && on_config_param;
    wire logic commit = edit_q == EDIT_ACTIVE && key_select;
    // Seconds tick
    always_ff @(posedge core_clk) begin
        if (reset || tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
        tick_q <= !reset && tick_cnt_q == 32'(TICK_CYCLES - 1);
        phase_q <= reset ? 1'b0 : phase_q ^ tick_q;
    end
    always_ff @(posedge core_clk) begin
        if (reset || key_press || trouble) begin
            idle_q <= 9'd0;
        end else if (tick_q && idle_q != AUTO_5M_S) begin
            idle_q <= idle_q + 9'd1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            relight_q <= 3'd0;
        end else if (key_press) begin
            relight_q <= RELIGHT_S;
        end else if (tick_q && relight_q != 3'd0) begin
            relight_q <= relight_q - 3'd1;
        end
    end
    // Edit state machine
    always_ff @(posedge core_clk) begin
        if (reset) begin
            edit_q <= EDIT_IDLE;
        end else begin
            case (edit_q)
                EDIT_IDLE: edit_q <= edit_start ? EDIT_ACTIVE : EDIT_IDLE;
                EDIT_ACTIVE: edit_q <= commit ? EDIT_IDLE : EDIT_ACTIVE;
                default: edit_q <= EDIT_IDLE;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            style_q <= STYLE_RST;
            delay_q <= DELAY_RST;
            manual_q <= MANUAL_RST;
        end else if (commit) begin
            style_q <= stage_q[STYLE_LSB +: 2];
            delay_q <= stage_q[DELAY_LSB +: 3];
            manual_q <= stage_q[MANUAL_LSB +: 4];
        end else if (wr_ctrl) begin
            style_q <= ctrl_new[STYLE_LSB +: 2];
            delay_q <= ctrl_new[DELAY_LSB +: 3];
            manual_q <= ctrl_new[MANUAL_LSB +: 4];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage_q <= 32'h0000_0000;
        end else if (wr_stage) begin
            stage_q <= stage_new & 32'h0000_0F73;
        end
    end
    // Write channel
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                s_axi_awready <= 1'b0;
                aw_have_q <= 1'b1;
            end
            if (w_hs) begin
                s_axi_wready <= 1'b0;
                w_have_q <= 1'b1;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ctrl | wr_stage | wr_status) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (aw_hs) begin
            awaddr_q <= s_axi_awaddr;
        end
        if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
    end
    // Read channel
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_ctrl | rd_stage | rd_status) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // Display content decode
    // plain style shows value
    wire logic style_alt = style_q == STYLE_ALTERNATE;
    wire logic style_tag = style_q == STYLE_TAG_ONLY;
    wire logic show_tag_d = any_alarm && (style_tag || (style_alt && phase_q));
    wire logic tag_second_d = !first_alarm || (second_alarm && style_tag && phase_q);
    wire logic flash_d = any_alarm && style_q == STYLE_FLASH;
    wire logic pv_on_d = !auto_blank && !mask[MASK_PV];
    wire logic sv_on_d = !auto_blank && !mask[MASK_SV];
    wire logic lamps_d = !mask[MASK_LAMP];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pv_on <= 1'b1;
            sv_on <= 1'b1;
            pv_show_tag <= 1'b0;
            pv_tag_second <= 1'b0;
            pv_flash <= 1'b0;
            pv_lamp_on <= 1'b1;
            pv_lamp_blink <= 1'b0;
            sv_lamp_on <= 1'b1;
            other_lamps_on <= 1'b1;
            digit_blink <= 1'b0;
        end else begin
            pv_on <= pv_on_d;
            sv_on <= sv_on_d;
            pv_show_tag <= show_tag_d;
            pv_tag_second <= tag_second_d;
            pv_flash <= flash_d;
            pv_lamp_on <= lamps_d;
            pv_lamp_blink <= auto_blank;
            sv_lamp_on <= lamps_d;
            other_lamps_on <= lamps_d && !auto_blank;
            digit_blink <= edit_start || (edit_q == EDIT_ACTIVE && !commit);
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    plain_style_a: assert property (
        style_q == STYLE_PLAIN |=> !pv_show_tag && !pv_flash)
        else $error("plain style altered value");
    alt_style_a: assert property (
        style_alt && any_alarm && $stable(style_q) |=> pv_show_tag == $past(phase_q))
        else $error("alternate style wrong phase");
    flash_style_a: assert property (
        style_q == STYLE_FLASH && any_alarm |=> pv_flash && !pv_show_tag)
        else $error("flash style not flashing");
    tag_only_a: assert property (
        style_tag && any_alarm |=> pv_show_tag)
        else $error("tag style showed value");
    both_tags_a: assert property (
        style_tag && first_alarm && second_alarm |=> pv_tag_second == $past(phase_q))
        else $error("both tags not alternating");
    auto_time_a: assert property (
        delay_q == DELAY_15S && idle_q == 9'd15 && !trouble && manual_q == 4'h0
        |=> !pv_on && !sv_on)
        else $error("auto blank missed at fifteen seconds");
    auto_lamps_a: assert property (
        auto_blank |=> pv_lamp_blink && sv_lamp_on && !other_lamps_on && !pv_on)
        else $error("auto blank lamps wrong");
    no_blank_trouble_a: assert property (
        trouble |=> !pv_lamp_blink)
        else $error("auto blank during trouble");
    trouble_relight_a: assert property (
        trouble |=> pv_on && sv_on)
        else $error("trouble did not relight");
    manual_four_a: assert property (
        manual_q == 4'h4 && !trouble |=> !pv_on && !sv_on && !pv_lamp_on)
        else $error("choice four not fully blank");
    relight_key_a: assert property (
        key_press && manual_q == 4'h7 ##1 manual_q == 4'h7 |=> pv_on && sv_on)
        else $error("key did not relight");
    relight_hold_a: assert property (
        relight_kind && trouble |=> pv_on && sv_on && pv_lamp_on)
        else $error("trouble lost relight");
    edit_commit_a: assert property (
        commit |=> style_q == $past(stage_q[STYLE_LSB +: 2]) && !digit_blink)
        else $error("commit did not load");
    key_restart_a: assert property (
        key_press |=> idle_q == 9'd0 && relight_q == RELIGHT_S)
        else $error("key did not restart counters");
    reset_vals_a: assert property (
        $past(reset) |-> style_q == STYLE_RST && delay_q == DELAY_RST && manual_q == MANUAL_RST)
        else $error("reset values wrong");

    auto_seen_c: cover property (auto_blank ##1 key_press);
    relight_seen_c: cover property (relight_on && manual_q == 4'h8);
    both_alarm_c: cover property (style_tag && first_alarm && second_alarm ##1 tick_q);
    commit_seen_c: cover property (edit_start ##[1:20] commit);

endmodule

//--- testbench/fpdb_panel_model.sv
// Front panel key model: turns bench key requests into key pulses.
// Assumes requests are raised for one cycle at a rising core_clk edge.
`timescale 1ns/10ps
module fpdb_panel_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Requests from the bench
    input wire logic press_req,
    input wire logic select_req,
    // Key pulses towards the block
    output logic key_press,
    output logic key_select
);
    // Select key also counts as a key operation
    always_ff @(posedge core_clk) begin
        if (reset) begin
            key_press <= 1'b0;
            key_select <= 1'b0;
        end else begin
            key_press <= press_req | select_req;
            key_select <= select_req;
        end
    end
endmodule

//--- testbench/fpdb_top_test.sv
// Self-checking bench for the display blanking block.
// Assumes key pulses from the panel model and registers over AXI4-Lite.
`timescale 1ns/10ps
module fpdb_top_test;
    import fpdb_pkg::*;
    localparam int TICK = 10;
    localparam int LIMS [4] = '{15, 30, 60, 300};
    logic core_clk, reset, press_req, select_req, key_press, key_select, on_config_param;
    logic first_alarm, second_alarm, input_error, pv_on, sv_on, pv_show_tag, pv_tag_second;
    logic pv_flash, pv_lamp_on, pv_lamp_blink, sv_lamp_on, other_lamps_on, digit_blink;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, a, b;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0] exp3;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int e;

    fpdb_top #(.TICK_CYCLES(TICK)) fpdb_top_inst (
        .core_clk(core_clk), .reset(reset), .key_press(key_press), .key_select(key_select),
        .on_config_param(on_config_param), .first_alarm(first_alarm),
        .second_alarm(second_alarm), .input_error(input_error), .pv_on(pv_on), .sv_on(sv_on),
        .pv_show_tag(pv_show_tag), .pv_tag_second(pv_tag_second), .pv_flash(pv_flash),
        .pv_lamp_on(pv_lamp_on), .pv_lamp_blink(pv_lamp_blink), .sv_lamp_on(sv_lamp_on),
        .other_lamps_on(other_lamps_on), .digit_blink(digit_blink),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    fpdb_panel_model fpdb_panel_model_inst (
        .core_clk(core_clk), .reset(reset), .press_req(press_req),
        .select_req(select_req), .key_press(key_press), .key_select(key_select)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [3:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        s_axi_awaddr <= ad;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dt;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        dt = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic key(input logic sel);
        press_req <= ~sel;
        select_req <= sel;
        @(posedge core_clk);
        press_req <= 1'b0;
        select_req <= 1'b0;
    endtask

    initial begin
        reset = 1'b1;
        {press_req, select_req, on_config_param, first_alarm, second_alarm} = 5'h0;
        input_error = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        cyc(12);
        reset <= 1'b0;
        cyc(2);
        rd(CTRL_OFS, d, r);
        check("ctrl_reset", d, 32'h0000_0000);
        check("lit_reset", {pv_on, sv_on, other_lamps_on, pv_lamp_blink}, 4'hE);
        rd(4'hC, d, r);
        check("unmapped_rd", r, RESP_SLVERR);
        wr(4'hC, 32'h0000_0003, r);
        check("unmapped_wr", r, RESP_SLVERR);
        // Alarm display styles with the first alarm, then tag style with both alarms
        for (int s = 0; s < 4; s++) begin
            wr(CTRL_OFS, 32'(s), r);
            first_alarm <= 1'b1;
            cyc(3);
            a = {pv_show_tag, pv_flash};
            cyc(TICK);
            b = {pv_show_tag, pv_flash};
            check("tag_alternates", a[1] ^ b[1], s == 1);
            check("tag_shown", a[1] | b[1], s == 1 || s == 3);
            check("flash", a[0], s == 2);
            check("first_tag", pv_tag_second, 1'b0);
            first_alarm <= 1'b0;
            cyc(3);
        end
        {first_alarm, second_alarm} <= 2'b11;
        cyc(3);
        a[0] = pv_tag_second;
        cyc(TICK);
        check("tags_alternate", a[0] ^ pv_tag_second, 1'b1);
        check("tag_only", pv_show_tag, 1'b1);
        {first_alarm, second_alarm} <= 2'b00;
        // Auto blank for every timed delay code, 15 s to 5 min
        for (int k = 0; k < 4; k++) begin
            wr(CTRL_OFS, 32'(k + 1) << DELAY_LSB, r);
            key(1'b0);
            cyc((LIMS[k] - 2) * TICK);
            check("lit_before", {pv_on, sv_on}, 2'b11);
            cyc(4 * TICK);
            check("auto_blank", {pv_on, sv_on, sv_lamp_on, other_lamps_on, pv_lamp_blink},
                  5'b00101);
        end
        input_error <= 1'b1;
        cyc(3);
        check("error_relight", {pv_on, sv_on}, 2'b11);
        wr(CTRL_OFS, 32'(DELAY_15S) << DELAY_LSB, r);
        key(1'b0);
        cyc(20 * TICK);
        check("no_blank_trouble", {pv_on, sv_on, pv_lamp_blink}, 3'b110);
        input_error <= 1'b0;
        // Manual blanking choices
        for (int c = 0; c < 9; c++) begin
            wr(CTRL_OFS, 32'(c) << MANUAL_LSB, r);
            cyc(3);
            e = (c > 4) ? c - 4 : c;
            exp3 = {!(e == 2 || e >= 3), !(e == 1 || e >= 3), e != 4};
            check("manual_mask", {pv_on, sv_on, other_lamps_on, pv_lamp_on},
                  {exp3, exp3[0]});
            if (c > 4) begin
                key(1'b0);
                cyc(3);
                check("key_relight", {pv_on, sv_on, other_lamps_on}, 3'b111);
                cyc(7 * TICK);
                check("relight_end", {pv_on, sv_on, other_lamps_on}, exp3);
            end
        end
        key(1'b0);
        first_alarm <= 1'b1;
        cyc(8 * TICK);
        check("alarm_stays_lit", {pv_on, sv_on, other_lamps_on}, 3'b111);
        first_alarm <= 1'b0;
        cyc(3);
        check("blank_again", {pv_on, sv_on, other_lamps_on}, 3'b000);
        input_error <= 1'b1;
        cyc(3);
        check("manual_relight", {pv_on, sv_on}, 2'b11);
        rd(STATUS_OFS, d, r);
        check("status_trouble", {r, d[9], d[7:2]}, {RESP_OKAY, 7'h01});
        input_error <= 1'b0;
        // Edit and commit of a staged value
        wr(CTRL_OFS, 32'h0000_0000, r);
        wr(STAGE_OFS, 32'h0000_0312, r);
        on_config_param <= 1'b1;
        key(1'b1);
        cyc(3);
        check("edit_blink", digit_blink, 1'b1);
        key(1'b1);
        cyc(3);
        check("edit_done", digit_blink, 1'b0);
        rd(CTRL_OFS, d, r);
        check("committed", d, 32'h0000_0312);
        give_verdict();
    end
endmodule
